/* File: verilog/ifsb_pkg.sv */
// ---------------------------------------------------------------
// Shared constants for the flag status bank
// ---------------------------------------------------------------
package ifsb_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int IFSB_DATA_W = 16;   // Register data width
   localparam int IFSB_ADDR_W = 4;    // Register address width
   localparam int IFSB_NBANK = 3;     // Flag registers 2, 3 and 4
   localparam int IFSB_NEVT = 3;      // One event bit per bank

   // ------------------------------------------------------------
   // Register offsets (word index on the register port)
   // ------------------------------------------------------------
   localparam logic [IFSB_ADDR_W-1:0] IFSB_OFS_FLAG2 = 4'h0;  // irq_flag_status_2
   localparam logic [IFSB_ADDR_W-1:0] IFSB_OFS_FLAG3 = 4'h1;  // irq_flag_status_3
   localparam logic [IFSB_ADDR_W-1:0] IFSB_OFS_FLAG4 = 4'h2;  // irq_flag_status_4
   localparam logic [IFSB_ADDR_W-1:0] IFSB_OFS_EN2 = 4'h3;    // Enables for flag reg 2
   localparam logic [IFSB_ADDR_W-1:0] IFSB_OFS_EN3 = 4'h4;    // Enables for flag reg 3
   localparam logic [IFSB_ADDR_W-1:0] IFSB_OFS_EN4 = 4'h5;    // Enables for flag reg 4
   localparam logic [IFSB_ADDR_W-1:0] IFSB_OFS_ISTAT = 4'h6;  // Sticky event status
   localparam logic [IFSB_ADDR_W-1:0] IFSB_OFS_IMASK = 4'h7;  // Event mask

   // ------------------------------------------------------------
   // Implemented bit layouts
   // Reg 2: 15 timer6, 14 dma4, 13 unused, 12..9 compare 8..5,
   //        8..5 capture 6..3, 4 dma3, 3 can_a event,
   //        2 can_a rx, 1 spi_b event, 0 spi_b error
   // Reg 3: 15..14 unused, 13 dma5, 12 codec event, 11 codec error,
   //        10..9 unused, 8 can_b event, 7 can_b rx, 6 ext pin4,
   //        5 ext pin3, 4 timer9, 3 timer8, 2 i2c_b master,
   //        1 i2c_b slave, 0 timer7
   // Reg 4: 15..8 unused, 7 can_b tx, 6 can_a tx, 5 dma7, 4 dma6,
   //        3 unused, 2 uart_b error, 1 uart_a error, 0 unused
   // ------------------------------------------------------------
   localparam logic [IFSB_DATA_W-1:0] IFSB_MASK_FLAG2 = 16'hdfff;
   localparam logic [IFSB_DATA_W-1:0] IFSB_MASK_FLAG3 = 16'h39ff;
   localparam logic [IFSB_DATA_W-1:0] IFSB_MASK_FLAG4 = 16'h00f6;

   // ------------------------------------------------------------
   // Values after reset
   // ------------------------------------------------------------
   localparam logic [IFSB_DATA_W-1:0] IFSB_RST_FLAG = 16'h0000;
   localparam logic [IFSB_DATA_W-1:0] IFSB_RST_EN = 16'h0000;
   localparam logic [IFSB_NEVT-1:0] IFSB_RST_EVT = 3'h0;

endpackage

/* File: verilog/ifsb_bank_if.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Link between the control logic and one flag register
// ---------------------------------------------------------------
interface ifsb_bank_if
   import ifsb_pkg::*;
();
   logic [IFSB_DATA_W-1:0] set_req;   // Source request pulses
   logic wr_en;                       // Software write strobe
   logic [IFSB_DATA_W-1:0] wr_data;   // Software write value
   logic [IFSB_DATA_W-1:0] flags;     // Flag register contents
   logic new_evt;                     // A source raised a request

   // Flag register side
   modport flag_side (
      input set_req,
      input wr_en,
      input wr_data,
      output flags,
      output new_evt
   );

   // Control side
   modport ctrl_side (
      output set_req,
      output wr_en,
      output wr_data,
      input flags,
      input new_evt
   );
endinterface

/* File: verilog/ifsb_flag_reg.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// One 16-bit flag register with hardware set and software write
// ---------------------------------------------------------------
module ifsb_flag_reg
   import ifsb_pkg::*;
#(
   parameter logic [IFSB_DATA_W-1:0] IMPL_MASK = IFSB_MASK_FLAG2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   ifsb_bank_if.flag_side bank
);

   logic [IFSB_DATA_W-1:0] flag_reg;   // Pending flags
   logic [IFSB_DATA_W-1:0] flag_next;  // Next flag value
   logic [IFSB_DATA_W-1:0] set_mask;   // Requests on implemented bits

   // ------------------------------------------------------------
   // Next value: write replaces, hardware set wins over a clear
   // ------------------------------------------------------------
   always_comb begin
      set_mask = bank.set_req & IMPL_MASK;  // RL2
      if (bank.wr_en) begin
         // Ones set, zeros clear, unused bits ignored
         flag_next = (bank.wr_data & IMPL_MASK) | set_mask;  // RL4
      end else begin
         // Latch new requests, hold the rest
         flag_next = flag_reg | set_mask;  // RL14
      end
   end

   // Flag storage, clear at reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flag_reg <= IFSB_RST_FLAG;  // RL3
      end else begin
         flag_reg <= flag_next;  // RL1
      end
   end

   assign bank.flags = flag_reg;
   assign bank.new_evt = |set_mask;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_unused_bits_zero: assert property ((flag_reg & ~IMPL_MASK) == '0) // RL2
      else $error("Unused flag bit is set");

   a_hw_set_held: assert property (set_mask != '0 |=> // RL14
      (flag_reg & $past(set_mask)) == $past(set_mask))
      else $error("Source request did not set its flag");

   a_sw_write_value: assert property (bank.wr_en && set_mask == '0 |=> // RL4
      flag_reg == ($past(bank.wr_data) & IMPL_MASK))
      else $error("Software write not stored");

   a_flag_holds: assert property (!bank.wr_en && set_mask == '0 |=> // RL1
      $stable(flag_reg))
      else $error("Flag changed without cause");

endmodule

/* File: verilog/ifsb_flag_bank.sv */
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Flag reads one once its source requested
// RL2: Unused bits read zero, writes ignored
// RL3: All flags clear at power-on reset
// RL4: Software may read and write every flag
// RL5: Reg 2 upper byte: timer6, dma4, compares, capture6
// RL6: Reg 2: captures 5-3, dma3, can_a event/rx
// RL7: Reg 2 bits 1,0: spi_b event, error
// RL8: Reg 3: dma5, codec event/error, can_b event
// RL9: Reg 3: can_b rx, pins 4,3, timers 9,8
// RL10: Reg 3 bits 2-0: i2c_b master, slave, timer7
// RL11: Reg 4: can tx flags, dma7, dma6
// RL12: Reg 4 bits 2,1: uart_b, uart_a errors
// RL13: Request forwarded only when its enable set
// RL14: Hardware set beats software clear, same cycle
// RL15: Handler clears its flag before returning
module ifsb_flag_bank
   import ifsb_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [IFSB_ADDR_W-1:0] ADDR_I,
   input wire logic [IFSB_DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [IFSB_DATA_W-1:0] RDATA_O,
   input wire logic [IFSB_DATA_W-1:0] SRC_REQ2_I,
   input wire logic [IFSB_DATA_W-1:0] SRC_REQ3_I,
   input wire logic [IFSB_DATA_W-1:0] SRC_REQ4_I,
   output logic [IFSB_DATA_W-1:0] FLAG2_O,
   output logic [IFSB_DATA_W-1:0] FLAG3_O,
   output logic [IFSB_DATA_W-1:0] FLAG4_O,
   output logic [IFSB_DATA_W-1:0] REQ2_O,
   output logic [IFSB_DATA_W-1:0] REQ3_O,
   output logic [IFSB_DATA_W-1:0] REQ4_O,
   output logic IRQ_O
);

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------

   // Implemented bits of flag register k (0 = reg 2)
   function automatic logic [IFSB_DATA_W-1:0] bank_mask(input int k);
      logic [IFSB_DATA_W-1:0] m;
      m = IFSB_MASK_FLAG2;
      if (k == 1) begin
         m = IFSB_MASK_FLAG3;
      end else if (k == 2) begin
         m = IFSB_MASK_FLAG4;
      end
      return m;
   endfunction

   // Offset of register k in a group starting at base
   function automatic logic [IFSB_ADDR_W-1:0] group_ofs(
      input logic [IFSB_ADDR_W-1:0] base,
      input int k
   );
      logic [IFSB_ADDR_W-1:0] kk;
      kk = k[IFSB_ADDR_W-1:0];
      return base + kk;
   endfunction

   // ------------------------------------------------------------
   // Internal signals
   // ------------------------------------------------------------
   ifsb_bank_if bank_if[IFSB_NBANK] ();            // One link per flag register
   logic [IFSB_DATA_W-1:0] src_req[IFSB_NBANK];    // Source pulses per bank
   logic [IFSB_DATA_W-1:0] flags[IFSB_NBANK];      // Flag values per bank
   logic [IFSB_NEVT-1:0] evt;                      // Request seen per bank
   logic [IFSB_DATA_W-1:0] en_reg[IFSB_NBANK];     // Per-source enables
   logic [IFSB_DATA_W-1:0] req_reg[IFSB_NBANK];    // Forwarded requests
   logic [IFSB_NEVT-1:0] stat_reg;                 // Sticky event status
   logic [IFSB_NEVT-1:0] stat_next;                // Next event status
   logic [IFSB_NEVT-1:0] mask_reg;                 // Event mask
   logic [IFSB_NEVT-1:0] mask_next;                // Next event mask
   logic irq_reg;                                  // Interrupt line
   logic [IFSB_DATA_W-1:0] rd_data_next;           // Read mux output
   logic [IFSB_DATA_W-1:0] rdata_reg;              // Registered read data
   logic rd_stat;                                  // Read of event status
   logic wr_mask;                                  // Write of event mask

   // Gather source pulses into an array
   assign src_req[0] = SRC_REQ2_I;
   assign src_req[1] = SRC_REQ3_I;
   assign src_req[2] = SRC_REQ4_I;

   // ------------------------------------------------------------
   // Flag registers, one per bank
   // ------------------------------------------------------------
   for (genvar g = 0; g < IFSB_NBANK; g++) begin : g_bank
      // Drive the link: request pulses and decoded write
      assign bank_if[g].set_req = src_req[g];
      assign bank_if[g].wr_en = WR_I && (ADDR_I == group_ofs(IFSB_OFS_FLAG2, g));
      assign bank_if[g].wr_data = WDATA_I;
      assign flags[g] = bank_if[g].flags;
      assign evt[g] = bank_if[g].new_evt;

      // Bit layout fixed by the implemented-bit mask
      ifsb_flag_reg #(
         .IMPL_MASK(bank_mask(g))
      ) u_flag (
         .clk_i(CLK_I),
         .rst_i(RST_I),
         .bank(bank_if[g])
      );

      // Enable register for this bank, unused bits held at zero
      always_ff @(posedge CLK_I or posedge RST_I) begin
         if (RST_I) begin
            en_reg[g] <= IFSB_RST_EN;
         end else if (WR_I && (ADDR_I == group_ofs(IFSB_OFS_EN2, g))) begin
            en_reg[g] <= WDATA_I & bank_mask(g);
         end
      end

      // Forward a pending flag only while enabled
      always_ff @(posedge CLK_I or posedge RST_I) begin
         if (RST_I) begin
            req_reg[g] <= IFSB_RST_FLAG;
         end else begin
            req_reg[g] <= flags[g] & en_reg[g];  // RL13
         end
      end
   end

   // Flag outputs come straight from the flag flip-flops
   assign FLAG2_O = flags[0];  // RL5 RL6 RL7
   assign FLAG3_O = flags[1];  // RL8 RL9 RL10
   assign FLAG4_O = flags[2];  // RL11 RL12
   assign REQ2_O = req_reg[0];
   assign REQ3_O = req_reg[1];
   assign REQ4_O = req_reg[2];

   // ------------------------------------------------------------
   // Event status and mask
   // ------------------------------------------------------------

   // Strobes for the two event registers
   assign rd_stat = RD_I && (ADDR_I == IFSB_OFS_ISTAT);
   assign wr_mask = WR_I && (ADDR_I == IFSB_OFS_IMASK);

   // Read clears; a new event in that cycle still lands
   always_comb begin
      stat_next = (rd_stat ? IFSB_RST_EVT : stat_reg) | evt;
      mask_next = wr_mask ? WDATA_I[IFSB_NEVT-1:0] : mask_reg;
   end

   // Sticky status bits
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         stat_reg <= IFSB_RST_EVT;
      end else begin
         stat_reg <= stat_next;
      end
   end

   // Mask bits
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         mask_reg <= IFSB_RST_EVT;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // Interrupt follows the unmasked status without a lag
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(stat_next & mask_next);
      end
   end

   assign IRQ_O = irq_reg;

   // ------------------------------------------------------------
   // Register read path
   // ------------------------------------------------------------

   // Select the addressed register, unmapped reads as zero
   always_comb begin
      rd_data_next = '0;
      unique case (ADDR_I)
         IFSB_OFS_FLAG2: begin
            rd_data_next = flags[0];  // RL5 RL6 RL7
         end
         IFSB_OFS_FLAG3: begin
            rd_data_next = flags[1];  // RL8 RL9 RL10
         end
         IFSB_OFS_FLAG4: begin
            rd_data_next = flags[2];  // RL11 RL12
         end
         IFSB_OFS_EN2: begin
            rd_data_next = en_reg[0];
         end
         IFSB_OFS_EN3: begin
            rd_data_next = en_reg[1];
         end
         IFSB_OFS_EN4: begin
            rd_data_next = en_reg[2];
         end
         IFSB_OFS_ISTAT: begin
            rd_data_next = {{(IFSB_DATA_W-IFSB_NEVT){1'b0}}, stat_reg};
         end
         IFSB_OFS_IMASK: begin
            rd_data_next = {{(IFSB_DATA_W-IFSB_NEVT){1'b0}}, mask_reg};
         end
         default: begin
            rd_data_next = '0;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rdata_reg <= '0;
      end else if (RD_I) begin
         rdata_reg <= rd_data_next;  // RL4
      end else begin
         rdata_reg <= '0;
      end
   end

   assign RDATA_O = rdata_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic post_rst_reg;  // High in the first cycle after reset

   // Marks the first clocked cycle after release
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         post_rst_reg <= 1'b1;
      end else begin
         post_rst_reg <= 1'b0;
      end
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   // Read strobes of the flag registers
   sequence s_rd_flag2;
      RD_I && ADDR_I == IFSB_OFS_FLAG2;
   endsequence

   sequence s_rd_flag3;
      RD_I && ADDR_I == IFSB_OFS_FLAG3;
   endsequence

   sequence s_rd_flag4;
      RD_I && ADDR_I == IFSB_OFS_FLAG4;
   endsequence

   a_reset_clears_all: assert property (post_rst_reg |-> // RL3
      FLAG2_O == '0 && FLAG3_O == '0 && FLAG4_O == '0 && IRQ_O == 1'b0)
      else $error("Flags not clear after reset");

   a_read_flag2: assert property (s_rd_flag2 |=> // RL5 RL6 RL7
      RDATA_O == $past(FLAG2_O) && (RDATA_O & ~IFSB_MASK_FLAG2) == '0)
      else $error("Flag register 2 read mismatch");

   a_read_flag3: assert property (s_rd_flag3 |=> // RL8 RL9 RL10
      RDATA_O == $past(FLAG3_O) && (RDATA_O & ~IFSB_MASK_FLAG3) == '0)
      else $error("Flag register 3 read mismatch");

   a_read_flag4: assert property (s_rd_flag4 |=> // RL11 RL12
      RDATA_O == $past(FLAG4_O) && (RDATA_O & ~IFSB_MASK_FLAG4) == '0)
      else $error("Flag register 4 read mismatch");

   a_req_gated: assert property (##1 REQ2_O == $past(FLAG2_O & en_reg[0]) // RL13
      && REQ3_O == $past(FLAG3_O & en_reg[1])
      && REQ4_O == $past(FLAG4_O & en_reg[2]))
      else $error("Forwarded request not gated by enable");

   a_set_beats_clear: assert property ((bank_if[0].wr_en && // RL14
      SRC_REQ2_I[15] && !WDATA_I[15]) |=> FLAG2_O[15])
      else $error("Software clear won over hardware set");

endmodule

/* File: testbench/ifsb_src_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Peripheral request sources facing the flag bank
// ------------------------------------------------------------
module ifsb_src_model
   import ifsb_pkg::*;
(
   input wire logic fire_i,
   input wire logic [1:0] sel_i,
   input wire logic [IFSB_DATA_W-1:0] bits_i,
   output logic [IFSB_DATA_W-1:0] req2_o,
   output logic [IFSB_DATA_W-1:0] req3_o,
   output logic [IFSB_DATA_W-1:0] req4_o
);
   // Pulse every selected source while fired, unused positions included
   // so that the bank must drop requests it has no flag for
   always_comb begin
      req2_o = (fire_i && sel_i == 2'h0) ? bits_i : 16'h0000;
      req3_o = (fire_i && sel_i == 2'h1) ? bits_i : 16'h0000;
      req4_o = (fire_i && sel_i == 2'h2) ? bits_i : 16'h0000;
   end
endmodule

/* File: testbench/test_interrupt_flag_status_bank.sv */
`timescale 1ns/1ps
module test_interrupt_flag_status_bank;
   import ifsb_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic fire = 1'b0;              // Source pulse request
   logic [1:0] sel = 2'h0;         // Bank the pulse goes to
   logic [15:0] bits = 16'h0000;   // Sources pulsed
   logic [15:0] src [3];
   logic [15:0] flag [3];
   logic [15:0] req [3];
   logic irq;
   logic rd_pend = 1'b0;           // Read data due this cycle
   logic [15:0] exp_q [$];         // Expected read data, oldest first
   logic [15:0] lfsr = 16'h4d8b;
   logic [15:0] r;
   int fails = 0;
   int check_count = 0;
   // Implemented flag positions per bank
   logic [15:0] impl [3] = '{16'hdfff, 16'h39ff, 16'h00f6};

   // ------------------------------------------------------------
   // Design and sources
   // ------------------------------------------------------------
   ifsb_flag_bank ifsb_flag_bank_inst (
      .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .SRC_REQ2_I(src[0]), .SRC_REQ3_I(src[1]), .SRC_REQ4_I(src[2]),
      .FLAG2_O(flag[0]), .FLAG3_O(flag[1]), .FLAG4_O(flag[2]),
      .REQ2_O(req[0]), .REQ3_O(req[1]), .REQ4_O(req[2]), .IRQ_O(irq)
   );
   ifsb_src_model ifsb_src_model_inst (
      .fire_i(fire), .sel_i(sel), .bits_i(bits),
      .req2_o(src[0]), .req3_o(src[1]), .req4_o(src[2])
   );

   // Free-running 100 MHz clock
   always #5 clk = ~clk;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] lfsr_step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One register port cycle; a read notes its expected data
   task automatic bus(input logic w, input logic r_s, input logic [3:0] a,
                      input logic [15:0] d, input logic [15:0] e);
      wr <= w;
      rd <= r_s;
      addr <= a;
      wdata <= d;
      if (r_s) begin
         exp_q.push_back(e);
      end
      @(posedge clk);
   endtask

   // Raise source pulses, taken at the next edge
   task automatic pulse(input logic [1:0] k, input logic [15:0] b);
      fire <= 1'b1;
      sel <= k;
      bits <= b;
   endtask

   // Quiet cycle, then stop at the falling edge to look at outputs
   // Any source pulse ends right after the edge that took it
   task automatic look();
      bus(1'b0, 1'b0, 4'h0, 16'h0000, 16'h0000);
      fire <= 1'b0;
      @(negedge clk);
   endtask

   task automatic complete_run();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Read data watcher
   // ------------------------------------------------------------
   always @(posedge clk) begin
      rd_pend <= rd;
   end
   always @(negedge clk) begin
      if (rd_pend) begin
         if (exp_q.size() == 0) begin
            // Read data with no read noted counts as a mismatch
            check_count++;
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, rdata, 16'h0000);
         end else begin
            chk(rdata, exp_q.pop_front());
         end
      end else begin
         // Read data stands only in the cycle after the strobe
         chk(rdata, 16'h0000);
      end
   end

   // Hang guard
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      complete_run();
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Every index, mapped or not, reads zero after reset
      for (int i = 0; i < 16; i++) bus(1'b0, 1'b1, i[3:0], 16'h0000, 16'h0000);
      // Fill flags and enables, write an unmapped index
      for (int i = 0; i < 6; i++) bus(1'b1, 1'b0, i[3:0], 16'hffff, 16'h0000);
      bus(1'b1, 1'b0, 4'h8, 16'hffff, 16'h0000);
      for (int i = 0; i < 6; i++) bus(1'b0, 1'b1, i[3:0], 16'h0000, impl[i % 3]);
      bus(1'b0, 1'b1, 4'h8, 16'h0000, 16'h0000);
      look();
      for (int i = 0; i < 3; i++) chk(flag[i], impl[i]);
      for (int i = 0; i < 3; i++) chk(req[i], impl[i]);
      @(posedge clk);
      // Handler style clear, back to back
      for (int i = 0; i < 3; i++) bus(1'b1, 1'b0, i[3:0], 16'h0000, 16'h0000);
      for (int i = 0; i < 3; i++) bus(1'b0, 1'b1, i[3:0], 16'h0000, 16'h0000);
      look();
      chk(req[0], 16'h0000);
      @(posedge clk);
      // Only timer six enabled in bank 2, every source of bank 2 fires
      bus(1'b1, 1'b0, 4'h3, 16'h8000, 16'h0000);
      pulse(2'h0, 16'hffff);
      look();
      chk(flag[0], 16'hdfff);
      @(posedge clk);
      look();
      chk(req[0], 16'h8000);
      @(posedge clk);
      bus(1'b0, 1'b1, 4'h6, 16'h0000, 16'h0001);
      // Random requests against a same-cycle clear of the bank
      for (int k = 0; k < 3; k++) begin
         lfsr = lfsr_step(lfsr);
         r = lfsr | 16'h0002;
         pulse(k[1:0], r);
         bus(1'b1, 1'b0, k[3:0], 16'h0000, 16'h0000);
         fire <= 1'b0;
         bus(1'b0, 1'b1, k[3:0], 16'h0000, r & impl[k]);
      end
      // Sticky status, cleared by its read; mask still zero
      bus(1'b0, 1'b1, 4'h6, 16'h0000, 16'h0007);
      bus(1'b0, 1'b1, 4'h6, 16'h0000, 16'h0000);
      look();
      chk({15'h0000, irq}, 16'h0000);
      @(posedge clk);
      bus(1'b1, 1'b0, 4'h7, 16'hffff, 16'h0000);
      bus(1'b0, 1'b1, 4'h7, 16'h0000, 16'h0007);
      // Only bank 3 unmasked
      bus(1'b1, 1'b0, 4'h7, 16'h0002, 16'h0000);
      pulse(2'h0, 16'h0001);
      look();
      chk({15'h0000, irq}, 16'h0000);
      @(posedge clk);
      pulse(2'h1, 16'h0001);
      look();
      chk({15'h0000, irq}, 16'h0001);
      @(posedge clk);
      bus(1'b0, 1'b1, 4'h6, 16'h0000, 16'h0003);
      look();
      chk({15'h0000, irq}, 16'h0000);
      complete_run();
   end
endmodule
